/* File: bench/tb_voice_activity_decision.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_voice_activity_decision;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, lag1, lag2;
   logic [31:0] pwdata, prdata, ra_data, pvad_fp, acf0_fp, thr, base, rdv;
   logic        ra_we, frame_strobe, stat_flag, tone_flag, lag_strobe;
   logic        vad_flag, frame_done, busy, last_err;
   logic [3:0]  ra_idx;
   int          errors, comparisons, cycles, burst, hang, seed;
   bit          exp_q[$];
   int          pat[18] = '{1, 1, 2, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0,
                            0, 0, 0};
   localparam logic [31:0] HI = {16'h0014, 16'h4000};

   vadd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ra_we(ra_we),
      .ra_idx(ra_idx), .ra_data(ra_data), .frame_strobe(frame_strobe),
      .pvad_fp(pvad_fp), .acf0_fp(acf0_fp), .stat_flag(stat_flag),
      .tone_flag(tone_flag), .lag_strobe(lag_strobe), .lag1(lag1),
      .lag2(lag2), .vad_flag(vad_flag), .frame_done(frame_done),
      .busy(busy));
   vadd_enc_model u_enc (.pclk(pclk), .ra_we(ra_we), .ra_idx(ra_idx),
      .ra_data(ra_data), .frame_strobe(frame_strobe), .pvad_fp(pvad_fp),
      .acf0_fp(acf0_fp), .stat_flag(stat_flag), .tone_flag(tone_flag),
      .lag_strobe(lag_strobe), .lag1(lag1), .lag2(lag2));

   always #25 pclk = ~pclk;

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // hang guard, far above the expected run length
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         errors++;
         give_verdict();
      end
   end

   // monitor: each finished frame consumes the oldest note
   always @(posedge pclk)
   begin
      if (frame_done === 1'b1)
      begin
         if (exp_q.size() == 0)
            errors++;
         else
            check({31'h0, vad_flag},
                  {31'h0, exp_q.pop_front()});
      end
   end

   // apb master: request held until pready seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         errors++;
      {rdv, last_err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'b0, a, '0);
      check(rdv & m, e);
   endtask : rd

   // reference hangover model, noted before the strobe goes out
   task automatic frm(input logic [31:0] p, input logic [31:0] a,
                      input logic s, input logic t, input bit vv);
      int n;
      burst = vv ? burst + 1 : 0;
      if (burst >= 3)
         {hang, burst} = {32'sd10, 32'sd3};
      exp_q.push_back(vv || hang >= 0);
      if (hang >= 0)
         hang--;
      u_enc.frame(p, a, s, t);
      // busy seen one edge after the strobe was taken
      @(posedge pclk);
      check({31'h0, busy}, 32'h1);
      n = 0;
      while (frame_done !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40)
         errors++;
   endtask : frm

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {seed, burst, hang} = {32'sd47, 32'sd0, -32'sd1};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(vadd_pkg::A_THR, '1, vadd_pkg::THR_INIT_FP);
      rd(vadd_pkg::A_RVAD, '1, vadd_pkg::RVAD0_INIT);
      rd(vadd_pkg::A_RVAD + 8'h04, '1, '0);
      rd(vadd_pkg::A_STAT, '1, 32'h0000F804);
      rd(8'h80, '1, '0);
      check({31'h0, last_err}, 32'h1);
      base = $random(seed);
      u_enc.load(base);
      // floor frames: above, equal and below the floor threshold
      foreach (pat[i])
         frm(pat[i] == 2 ? vadd_pkg::PLEV_FP :
             {pat[i] == 1 ? 16'h0015 : 16'h0011, 2'b01, 14'($random(seed))},
             {16'h000A, 16'h4000}, 1'b1, 1'b0, pat[i] == 1);
      thr = vadd_pkg::PLEV_FP;
      rd(vadd_pkg::A_THR, '1, thr);
      rd(vadd_pkg::A_RVAD, '1, vadd_pkg::RVAD0_INIT);
      u_enc.lags(8'h1E, 8'h32);
      rd(vadd_pkg::A_STAT, 32'h4, '0);
      // only steady, non-tone frames may adapt
      for (int k = 0; k < 3; k++)
      begin
         frm({16'h0005, 16'h4000}, HI, k != 1, k == 0, 1'b0);
         if (k == 2)
            thr[15:0] = thr[15:0] - (thr[15:0] >> 5);
         rd(vadd_pkg::A_THR, '1, thr);
      end
      rd(vadd_pkg::A_RVAD, '1, base);
      rd(vadd_pkg::A_RVAD + 8'h20, '1, base + 32'h8);
      frm(thr, HI, 1'b1, 1'b0, 1'b0);
      thr[15:0] = thr[15:0] + (thr[15:0] >> 4);
      rd(vadd_pkg::A_THR, '1, thr);
      // lag differences of one count, of two do not
      u_enc.lags(8'h33, 8'h32);
      u_enc.lags(8'h33, 8'h32);
      rd(vadd_pkg::A_STAT, 32'h4, 32'h4);
      frm({16'h0005, 16'h4000}, HI, 1'b1, 1'b0, 1'b0);
      rd(vadd_pkg::A_THR, '1, thr);
      u_enc.lags(8'h34, 8'h36);
      rd(vadd_pkg::A_STAT, 32'h4, '0);
      // soft reset restores the threshold and status starting values
      apb(1'b1, vadd_pkg::A_CTRL, 32'h1);
      {burst, hang} = {32'sd0, -32'sd1};
      rd(vadd_pkg::A_THR, '1, vadd_pkg::THR_INIT_FP);
      rd(vadd_pkg::A_STAT, '1, 32'h0000F804);
      rd(vadd_pkg::A_CTRL, '1, '0);
      repeat (4) @(posedge pclk);
      if (exp_q.size() != 0)
         errors++;
      give_verdict();
   end
endmodule : tb_voice_activity_decision
`default_nettype wire

/* File: bench/vadd_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vadd_enc_model
(
   input  wire logic        pclk,
   output logic             ra_we,
   output logic [3:0]       ra_idx,
   output logic [31:0]      ra_data,
   output logic             frame_strobe,
   output logic [31:0]      pvad_fp,
   output logic [31:0]      acf0_fp,
   output logic             stat_flag,
   output logic             tone_flag,
   output logic             lag_strobe,
   output logic [7:0]       lag1,
   output logic [7:0]       lag2
);
   // quiet outputs before the first frame
   initial
   begin
      {ra_we, ra_idx, ra_data, frame_strobe, pvad_fp, acf0_fp} = '0;
      {stat_flag, tone_flag, lag_strobe, lag1, lag2} = '0;
   end
   // all nine words land before any strobe
   task automatic load(input logic [31:0] b);
      for (int i = 0; i < 9; i++)
      begin
         @(posedge pclk);
         ra_we   <= 1'b1;
         ra_idx  <= 4'(i);
         ra_data <= b + 32'(i);
      end
      @(posedge pclk);
      ra_we   <= 1'b0;
      ra_data <= ~ra_data; // released lines must not look valid
   endtask : load
   // one-cycle strobe; inverted values after it so no stale hit
   task automatic frame(input logic [31:0] p, input logic [31:0] a,
                        input logic s, input logic t);
      @(posedge pclk);
      frame_strobe <= 1'b1;
      {pvad_fp, acf0_fp, stat_flag, tone_flag} <= {p, a, s, t};
      @(posedge pclk);
      frame_strobe <= 1'b0;
      {pvad_fp, acf0_fp, stat_flag, tone_flag} <= ~{p, a, s, t};
   endtask : frame
   // lags only after the frame decision is done
   task automatic lags(input logic [7:0] l1,
                       input logic [7:0] l2);
      @(posedge pclk);
      lag_strobe <= 1'b1;
      {lag1, lag2} <= {l1, l2};
      @(posedge pclk);
      lag_strobe <= 1'b0;
      {lag1, lag2} <= ~{l1, l2};
   endtask : lags
endmodule : vadd_enc_model
`default_nettype wire

/* File: src/vadd_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module vadd_mem
#(
   parameter logic [31:0] INIT0 = 32'h00000000
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clr,
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  raddr,
   output var  logic [31:0] rdata_r
);
   logic [31:0] mem [vadd_pkg::ACF_N];

   // one flop word per entry; entry 0 has its own start value
   for (genvar i = 0; i < vadd_pkg::ACF_N; i++)
   begin : g_ent
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            mem[i] <= (i == 0) ? INIT0 : 32'h00000000;
         else if (clr)
            mem[i] <= (i == 0) ? INIT0 : 32'h00000000;
         else if (we && waddr == 4'(i))
            mem[i] <= wdata;
      end
   end

   // registered read; out-of-range index reads zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_r <= 32'h00000000;
      else if (raddr < vadd_pkg::ACF_N)
         rdata_r <= mem[raddr];
      else
         rdata_r <= 32'h00000000;
   end
endmodule : vadd_mem
`default_nettype wire

/* File: src/vadd_pkg.sv */
package vadd_pkg;

   // fixed widths and depths
   localparam int unsigned ACF_W = 32;
   localparam logic [3:0]  ACF_N = 4'h9;
   localparam int unsigned LAG_W = 8;

   // pseudo-float words pack {exponent[31:16], mantissa[15:0]},
   // value = 2^exponent * mantissa / 32768, mantissa >= 16384
   localparam logic [31:0] PTH_FP      = 32'h00117EF4;
   localparam logic [31:0] MARGIN_FP   = 32'h001B421F;
   localparam logic [31:0] PLEV_FP     = 32'h001354A3;
   localparam logic [31:0] THR_INIT_FP = 32'h001469CB;
   localparam logic [31:0] FAC_FP      = 32'h00024333;

   // stored-state starting values and counts
   localparam logic [31:0] RVAD0_INIT  = 32'h00000006;
   localparam logic [2:0]  BURST_CONST = 3'h3;
   localparam logic [4:0]  HANG_CONST  = 5'h0A;
   localparam logic [4:0]  HANG_INIT   = 5'h1F;
   localparam logic [3:0]  ADP_MAX     = 4'h8;
   localparam logic [7:0]  LTHRESH     = 8'h02;
   localparam logic [2:0]  NTHRESH     = 3'h4;
   localparam logic [7:0]  LAG0_INIT   = 8'h12;
   localparam logic        PTCH_INIT   = 1'b1;

   // register byte offsets
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STAT      = 8'h04;
   localparam logic [7:0]  A_THR       = 8'h08;
   localparam logic [7:0]  A_LAG       = 8'h0C;
   localparam logic [7:0]  A_RVAD      = 8'h40;
   localparam logic [7:0]  A_RVAD_END  = 8'h64;

   // field positions
   localparam int unsigned CTRL_RST_B  = 0;
   localparam int unsigned ST_VAD_B    = 0;
   localparam int unsigned ST_VVAD_B   = 1;
   localparam int unsigned ST_PTCH_B   = 2;
   localparam int unsigned ST_BUSY_B   = 3;
   localparam int unsigned ST_ADC_LSB  = 4;
   localparam int unsigned ST_BUR_LSB  = 8;
   localparam int unsigned ST_HANG_LSB = 11;
   localparam int unsigned LG_OLD_LSB  = 8;
   localparam int unsigned LG_VOLD_LSB = 10;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_ADAPT  = 2'b01,
      ST_COPY   = 2'b10,
      ST_DECIDE = 2'b11
   } vadd_state_t;

   // a < b for normalised pseudo-floats
   function automatic logic fp_lt(input logic [31:0] a,
                                  input logic [31:0] b);
      logic signed [15:0] ea;
      logic signed [15:0] eb;
      ea = signed'(a[31:16]);
      eb = signed'(b[31:16]);
      return (ea < eb) || ((ea == eb) && (a[15:0] < b[15:0]));
   endfunction : fp_lt

   function automatic logic [31:0] fp_mul(input logic [31:0] a,
                                          input logic [31:0] b);
      logic [31:0] p;
      logic [15:0] e;
      p = a[15:0] * b[15:0];
      e = a[31:16] + b[31:16];
      if (p[29])
         return {e, p[30:15]};
      return {e - 16'h0001, p[29:14]};
   endfunction : fp_mul

   // times (1 - 1/32)
   function automatic logic [31:0] fp_dn(input logic [31:0] a);
      logic [15:0] m;
      m = a[15:0] - {5'h00, a[15:5]};
      if (m[14])
         return {a[31:16], m};
      return {a[31:16] - 16'h0001, m[14:0], 1'b0};
   endfunction : fp_dn

   // times (1 + 1/16)
   function automatic logic [31:0] fp_up(input logic [31:0] a);
      logic [16:0] m;
      m = {1'b0, a[15:0]} + {5'h00, a[15:4]};
      if (m[15])
         return {a[31:16] + 16'h0001, m[16:1]};
      return {a[31:16], m[15:0]};
   endfunction : fp_up

   function automatic logic [31:0] fp_add(input logic [31:0] a,
                                          input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [15:0] d;
      logic [15:0] sh;
      logic [16:0] s;
      x = fp_lt(a, b) ? b : a;
      y = fp_lt(a, b) ? a : b;
      d = x[31:16] - y[31:16];
      sh = (d > 16'h000F) ? 16'h0000 : (y[15:0] >> d[3:0]);
      s = {1'b0, x[15:0]} + {1'b0, sh};
      if (s[15])
         return {x[31:16] + 16'h0001, s[16:1]};
      return {x[31:16], s[15:0]};
   endfunction : fp_add

endpackage : vadd_pkg

/* File: src/vadd_top.sv */
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) threshold adaptation is evaluated once per 20 ms frame strobe
// (R2) input energy below floor loads threshold floor, filter vector kept
// (R3) adapt only when steady spectrum, not periodic, no tone
// (R4) adaptation copies reference autocorrelation into filter vector
// (R5) try threshold times 31/32; keep it if not below 2.1 x energy
// (R6) else take smaller of threshold x 17/16 and energy x 2.1
// (R7) adapted threshold never above filtered energy plus margin
// (R8) reset: threshold, vector element 0 six, rest and counter zero
// (R9) raw decision is filtered energy strictly above threshold
// (R10) burst counter counts raw-true frames, clears on false
// (R11) burst of three reloads holdover with ten, burst saturates
// (R12) voice flag is raw OR holdover non-negative; holdover decrements
// (R13) count lag pairs whose absolute difference is below two
// (R14) zeroth lag is previous frame second lag, eighteen at reset
// (R15) shift pair counts; periodic when both sum to four or more
// (R16) periodic flag updated after decision, true at reset
// (R17) reset returns every stored variable to its start value
// (R18) encoder loads all autocorrelation words before frame strobe
// (R19) energies and threshold are exponent and normalised mantissa
// (R20) floor, margin and threshold floor use fixed float constants
// (R21) one-cycle frame strobe in, done pulse when frame finished
// (R22) periodic flag computed on separate later lag strobe
module vadd_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ra_we,
   input  wire logic [3:0]  ra_idx,
   input  wire logic [31:0] ra_data,
   input  wire logic        frame_strobe,
   input  wire logic [31:0] pvad_fp,
   input  wire logic [31:0] acf0_fp,
   input  wire logic        stat_flag,
   input  wire logic        tone_flag,
   input  wire logic        lag_strobe,
   input  wire logic [7:0]  lag1,
   input  wire logic [7:0]  lag2,
   output var  logic        vad_flag,
   output var  logic        frame_done,
   output logic             busy
);
   vadd_pkg::vadd_state_t state_r;
   logic [31:0] pvad_r;
   logic [31:0] acf0_r;
   logic        stat_r;
   logic        tone_r;
   logic [31:0] thr_r;
   logic [3:0]  adcnt_r;
   logic [3:0]  cp_idx_r;
   logic [2:0]  burst_r;
   logic [4:0]  hang_r;
   logic        vvad_r;
   logic        ptch_r;
   logic [1:0]  old_r;
   logic [1:0]  vold_r;
   logic [7:0]  lag0_r;
   logic        ack_r;
   logic        sw_rst;
   logic        low_e;
   logic        adapt_go;
   logic [31:0] dec_fp;
   logic [31:0] inc_fp;
   logic [31:0] pf_fp;
   logic [31:0] lim_fp;
   logic [31:0] t1_fp;
   logic [31:0] thr_nxt;
   logic        vvad_now;
   logic [2:0]  burst_inc;
   logic        reload;
   logic [4:0]  hang_mid;
   logic        vad_nxt;
   logic        ptch_go;
   logic [7:0]  d1;
   logic [7:0]  d2;
   logic [1:0]  lag_cnt;
   logic        rv_hit;
   logic [31:0] rd_mux;
   logic        addr_ok;
   logic [31:0] stage_rd;
   logic [31:0] rvad_rd;
   logic        take;

   // reference vector staging, loaded by the encoder ahead of the strobe
   vadd_mem #(.INIT0(32'h00000000)) u_stage
   (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (sw_rst),
      .we      (ra_we && state_r == vadd_pkg::ST_IDLE),
      .waddr   (ra_idx),
      .wdata   (ra_data),
      .raddr   (cp_idx_r),
      .rdata_r (stage_rd)
   );

   // filter autocorrelation vector, written only by the copy walk
   vadd_mem #(.INIT0(vadd_pkg::RVAD0_INIT)) u_rvad
   (
      .pclk    (pclk),
      .presetn (presetn),                       // see (R8)
      .clr     (sw_rst),                        // see (R17)
      .we      (state_r == vadd_pkg::ST_COPY && cp_idx_r != 4'h0),
      .waddr   (cp_idx_r - 4'h1),               // see (R4)
      .wdata   (stage_rd),
      .raddr   (paddr[5:2] - 4'h0),
      .rdata_r (rvad_rd)
   );

   // apb: one wait cycle for every access, writes land with pready
   assign take   = psel && penable && ack_r;
   assign pready = take;
   assign sw_rst = take && pwrite && paddr == vadd_pkg::A_CTRL
                   && pwdata[vadd_pkg::CTRL_RST_B];   // see (R17)
   assign rv_hit = paddr >= vadd_pkg::A_RVAD
                   && paddr < vadd_pkg::A_RVAD_END && paddr[1:0] == 2'b00;
   assign addr_ok = rv_hit || paddr == vadd_pkg::A_CTRL
                    || paddr == vadd_pkg::A_STAT
                    || paddr == vadd_pkg::A_THR
                    || paddr == vadd_pkg::A_LAG;
   assign pslverr = take && !addr_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ack_r <= 1'b0;
      else
         ack_r <= psel && penable && !ack_r;
   end

   // read mux; the vector word comes from the memory's output flop
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (rv_hit)
         rd_mux = rvad_rd;
      else if (paddr == vadd_pkg::A_STAT)
      begin
         rd_mux[vadd_pkg::ST_VAD_B]  = vad_flag;
         rd_mux[vadd_pkg::ST_VVAD_B] = vvad_r;
         rd_mux[vadd_pkg::ST_PTCH_B] = ptch_r;
         rd_mux[vadd_pkg::ST_BUSY_B] = busy;
         rd_mux[vadd_pkg::ST_ADC_LSB +: 4]  = adcnt_r;
         rd_mux[vadd_pkg::ST_BUR_LSB +: 3]  = burst_r;
         rd_mux[vadd_pkg::ST_HANG_LSB +: 5] = hang_r;
      end
      else if (paddr == vadd_pkg::A_THR)
         rd_mux = thr_r;
      else if (paddr == vadd_pkg::A_LAG)
      begin
         rd_mux[7:0] = lag0_r;
         rd_mux[vadd_pkg::LG_OLD_LSB +: 2]  = old_r;
         rd_mux[vadd_pkg::LG_VOLD_LSB +: 2] = vold_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && penable && !ack_r)
         prdata <= rd_mux;
   end

   // frame sequencer; a strobe while busy is dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= vadd_pkg::ST_IDLE;
      else if (sw_rst)
         state_r <= vadd_pkg::ST_IDLE;
      else
         unique case (state_r)
            vadd_pkg::ST_IDLE:
               if (frame_strobe)
                  state_r <= vadd_pkg::ST_ADAPT;        // see (R1) (R21)
            vadd_pkg::ST_ADAPT:
               state_r <= adapt_go ? vadd_pkg::ST_COPY
                                   : vadd_pkg::ST_DECIDE;
            vadd_pkg::ST_COPY:
               if (cp_idx_r == vadd_pkg::ACF_N)
                  state_r <= vadd_pkg::ST_DECIDE;
            vadd_pkg::ST_DECIDE:
               state_r <= vadd_pkg::ST_IDLE;
         endcase
   end
   assign busy = state_r != vadd_pkg::ST_IDLE;

   // frame inputs captured on the strobe, held through the frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pvad_r <= 32'h00000000;
         acf0_r <= 32'h00000000;
         stat_r <= 1'b0;
         tone_r <= 1'b0;
      end
      else if (state_r == vadd_pkg::ST_IDLE && frame_strobe)
      begin
         pvad_r <= pvad_fp;                             // see (R19)
         acf0_r <= acf0_fp;
         stat_r <= stat_flag;
         tone_r <= tone_flag;
      end
   end

   // copy walk: read index k, write word k one cycle later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cp_idx_r <= 4'h0;
      else if (state_r == vadd_pkg::ST_COPY && !sw_rst)
         cp_idx_r <= cp_idx_r + 4'h1;
      else
         cp_idx_r <= 4'h0;
   end

   // threshold adaptation datapath, all in float words
   assign low_e    = vadd_pkg::fp_lt(acf0_r, vadd_pkg::PTH_FP);   // see (R20)
   assign adapt_go = !low_e && stat_r && !ptch_r && !tone_r;     // see (R3)
   assign dec_fp   = vadd_pkg::fp_dn(thr_r);
   assign inc_fp   = vadd_pkg::fp_up(thr_r);
   assign pf_fp    = vadd_pkg::fp_mul(pvad_r, vadd_pkg::FAC_FP);
   assign lim_fp   = vadd_pkg::fp_add(pvad_r, vadd_pkg::MARGIN_FP);
   // lowered value kept unless it fell below energy x 2.1
   assign t1_fp = !vadd_pkg::fp_lt(dec_fp, pf_fp) ? dec_fp      // see (R5)
                : vadd_pkg::fp_lt(inc_fp, pf_fp) ? inc_fp       // see (R6)
                : pf_fp;
   assign thr_nxt = vadd_pkg::fp_lt(lim_fp, t1_fp) ? lim_fp      // see (R7)
                  : t1_fp;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         thr_r <= vadd_pkg::THR_INIT_FP;                // see (R8)
      else if (sw_rst)
         thr_r <= vadd_pkg::THR_INIT_FP;
      else if (state_r == vadd_pkg::ST_ADAPT && low_e)
         thr_r <= vadd_pkg::PLEV_FP;                    // see (R2)
      else if (state_r == vadd_pkg::ST_ADAPT && adapt_go)
         thr_r <= thr_nxt;
   end

   // consecutive adapting frames, saturating; readable for tuning
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         adcnt_r <= 4'h0;                               // see (R8)
      else if (sw_rst)
         adcnt_r <= 4'h0;
      else if (state_r == vadd_pkg::ST_ADAPT)
         adcnt_r <= !adapt_go ? 4'h0
                  : (adcnt_r == vadd_pkg::ADP_MAX) ? adcnt_r
                  : adcnt_r + 4'h1;
   end

   // decision and hangover
   assign vvad_now  = vadd_pkg::fp_lt(thr_r, pvad_r);            // see (R9)
   assign burst_inc = vvad_now ? burst_r + 3'h1 : 3'h0;         // see (R10)
   assign reload    = burst_inc >= vadd_pkg::BURST_CONST;
   assign hang_mid  = reload ? vadd_pkg::HANG_CONST : hang_r;   // see (R11)
   assign vad_nxt   = vvad_now || !hang_mid[4];                 // see (R12)

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         burst_r    <= 3'h0;
         hang_r     <= vadd_pkg::HANG_INIT;
         vvad_r     <= 1'b0;
         vad_flag   <= 1'b0;
         frame_done <= 1'b0;
      end
      else if (sw_rst)
      begin
         burst_r    <= 3'h0;                            // see (R17)
         hang_r     <= vadd_pkg::HANG_INIT;
         vvad_r     <= 1'b0;
         vad_flag   <= 1'b0;
         frame_done <= 1'b0;
      end
      else
      begin
         frame_done <= state_r == vadd_pkg::ST_DECIDE;  // see (R21)
         if (state_r == vadd_pkg::ST_DECIDE)
         begin
            burst_r  <= reload ? vadd_pkg::BURST_CONST : burst_inc;
            hang_r   <= hang_mid[4] ? hang_mid : hang_mid - 5'h01;
            vvad_r   <= vvad_now;
            vad_flag <= vad_nxt;
         end
      end
   end

   // periodicity; only taken while idle and not on a new frame strobe,
   // so a lag strobe that meets a frame strobe is lost and the next adaptation keeps the older flag
   assign ptch_go = lag_strobe && state_r == vadd_pkg::ST_IDLE
                    && !frame_strobe;                   // see (R16) (R22)
   assign d1 = (lag1 >= lag0_r) ? lag1 - lag0_r : lag0_r - lag1;
   assign d2 = (lag2 >= lag1) ? lag2 - lag1 : lag1 - lag2;
   assign lag_cnt = {1'b0, d1 < vadd_pkg::LTHRESH}
                  + {1'b0, d2 < vadd_pkg::LTHRESH};     // see (R13)

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ptch_r <= vadd_pkg::PTCH_INIT;
         old_r  <= 2'h0;
         vold_r <= 2'h0;
         lag0_r <= vadd_pkg::LAG0_INIT;
      end
      else if (sw_rst)
      begin
         ptch_r <= vadd_pkg::PTCH_INIT;
         old_r  <= 2'h0;
         vold_r <= 2'h0;
         lag0_r <= vadd_pkg::LAG0_INIT;
      end
      else if (ptch_go)
      begin
         vold_r <= old_r;                               // see (R15)
         old_r  <= lag_cnt;
         ptch_r <= ({1'b0, lag_cnt} + {1'b0, old_r}) >= vadd_pkg::NTHRESH;
         lag0_r <= lag2;                                // see (R14)
      end
   end

   // checks; soft reset restarts all state but the captured frame inputs and apb flops, so it also disables them
   logic dis;
   assign dis = !presetn || sw_rst;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (dis);

   AST_PLEV_LOAD: assert property ( // see (R2)
      state_r == vadd_pkg::ST_ADAPT && low_e |=> thr_r == vadd_pkg::PLEV_FP)
      else $error("threshold floor not loaded on low energy");
   AST_HOLD_THR: assert property ( // see (R3)
      state_r == vadd_pkg::ST_ADAPT && !low_e && !adapt_go |=> $stable(thr_r))
      else $error("threshold moved without adaptation");
   AST_COPY_WALK: assert property ( // see (R4)
      state_r == vadd_pkg::ST_ADAPT && adapt_go
      |=> (state_r == vadd_pkg::ST_COPY && cp_idx_r == 4'h0)
          ##9 (state_r == vadd_pkg::ST_COPY && cp_idx_r == 4'h9)
          ##1 state_r == vadd_pkg::ST_DECIDE)
      else $error("vector copy walk wrong length");
   AST_DEC_KEEP: assert property ( // see (R5)
      state_r == vadd_pkg::ST_ADAPT && adapt_go
      && !vadd_pkg::fp_lt(dec_fp, pf_fp) && !vadd_pkg::fp_lt(lim_fp, dec_fp)
      |=> thr_r == $past(dec_fp))
      else $error("lowered threshold not kept");
   AST_CLAMP: assert property ( // see (R7)
      state_r == vadd_pkg::ST_ADAPT && adapt_go
      |=> !vadd_pkg::fp_lt(vadd_pkg::fp_add(pvad_r, vadd_pkg::MARGIN_FP),
                           thr_r))
      else $error("threshold above energy plus margin");
   AST_VVAD: assert property ( // see (R9)
      state_r == vadd_pkg::ST_DECIDE
      |=> vvad_r == vadd_pkg::fp_lt(thr_r, pvad_r))
      else $error("raw decision mismatch");
   AST_HANG_RELOAD: assert property ( // see (R11)
      state_r == vadd_pkg::ST_DECIDE && vvad_now && burst_r >= 3'h2
      |=> hang_r == 5'h09 && burst_r == 3'h3 && vad_flag)
      else $error("holdover reload wrong");
   AST_VAD_FLAG: assert property ( // see (R12)
      state_r == vadd_pkg::ST_DECIDE && !vvad_now
      |=> vad_flag == !$past(hang_r[4]) && burst_r == 3'h0)
      else $error("voice flag or burst clear wrong");
   AST_PTCH: assert property ( // see (R15)
      ptch_go |=> ptch_r == (({1'b0, old_r} + {1'b0, vold_r}) >= 3'h4))
      else $error("periodic flag wrong");
   AST_LAG0: assert property ( // see (R14)
      ptch_go |=> lag0_r == $past(lag2) && old_r == $past(lag_cnt))
      else $error("lag history not shifted");
   AST_DONE: assert property ( // see (R21)
      state_r == vadd_pkg::ST_IDLE && frame_strobe |-> ##[3:13] frame_done)
      else $error("frame done pulse missing");

   COV_ADAPT: cover property (state_r == vadd_pkg::ST_ADAPT && adapt_go);
   COV_LOW:   cover property (state_r == vadd_pkg::ST_ADAPT && low_e);
   COV_HANG:  cover property (state_r == vadd_pkg::ST_DECIDE && reload);
   COV_PTCH:  cover property (ptch_go ##1 ptch_r);
endmodule : vadd_top
`default_nettype wire
